// ===== dv/sdc_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// command pin checker
// ****************************************
module sdc_ctrl_chk
  import sdc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_req_valid,
  input wire sdc_req_s i_req,
  input wire logic o_req_ready,
  input wire logic o_req_reject,
  input wire sdc_pins_s o_pins,
  input wire logic o_self_refresh
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  logic [3:0] cmd;
  logic take;
  logic [7:0] exit_cnt;
  assign cmd = {o_pins.cs_n, o_pins.ras_n, o_pins.cas_n, o_pins.we_n};
  assign take = i_req_valid && o_req_ready;
  // saturates so a long run never wraps into a false early command
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      exit_cnt <= 8'hFF;
    end else if (o_self_refresh) begin
      exit_cnt <= 8'h00;
    end else if (exit_cnt != 8'hFF) begin
      exit_cnt <= exit_cnt + 8'h01;
    end
  end
  sequence s_write_cmd;
    cmd == 4'h4 && o_pins.write_mask == $past(i_req.write_mask);
  endsequence
  sequence s_act_cmd;
    cmd == 4'h3 && o_pins.bank == $past(i_req.bank);
  endsequence
  property p_cmd_one_cycle;
    !o_pins.cs_n |=> o_pins.cs_n;
  endproperty
  property p_take_gap;
    take |=> !o_req_ready;
  endproperty
  property p_cke_hold;
    $changed(o_pins.cke) |=> $stable(o_pins.cke) [*2];
  endproperty
  property p_rise_nop;
    $rose(o_pins.cke) |-> o_pins.cs_n || cmd == 4'h7;
  endproperty
  property p_fall_cmd;
    $fell(o_pins.cke) |-> o_pins.cs_n || cmd == 4'h7 || cmd == 4'h1;
  endproperty
  property p_sr_entry;
    $fell(o_pins.cke) && cmd == 4'h1 |-> ##[0:1] o_self_refresh;
  endproperty
  property p_read_delay;
    cmd == 4'h5 |-> exit_cnt >= 8'd199;
  endproperty
  property p_nonread_delay;
    !o_pins.cs_n && cmd != 4'h7 |-> exit_cnt >= 8'd19;
  endproperty
  property p_write;
    take && i_req.op == SDC_OP_WRITE |=> o_req_reject or s_write_cmd;
  endproperty
  property p_activate;
    take && i_req.op == SDC_OP_ACTIVATE |=> o_req_reject or s_act_cmd;
  endproperty
  property p_reject_quiet;
    o_req_reject |-> o_pins.cs_n ##1 !o_req_reject;
  endproperty
  property p_odt_sr;
    o_self_refresh && $past(o_self_refresh) |-> !o_pins.on_die_termination;
  endproperty
  a_cmd_one_cycle: assert property (p_cmd_one_cycle) else $error("command held");
  a_take_gap: assert property (p_take_gap) else $error("ready after take");
  a_cke_hold: assert property (p_cke_hold) else $error("cke hold short");
  a_rise_nop: assert property (p_rise_nop) else $error("cke rise with command");
  a_fall_cmd: assert property (p_fall_cmd) else $error("cke fall with command");
  a_sr_entry: assert property (p_sr_entry) else $error("self refresh not entered");
  a_read_delay: assert property (p_read_delay) else $error("early read");
  a_nonread_delay: assert property (p_nonread_delay) else $error("early command");
  a_write: assert property (p_write) else $error("write pins wrong");
  a_activate: assert property (p_activate) else $error("activate pins wrong");
  a_reject_quiet: assert property (p_reject_quiet) else $error("reject not quiet");
  a_odt_sr: assert property (p_odt_sr) else $error("odt in self refresh");
endmodule : sdc_ctrl_chk
bind sdc_ctrl sdc_ctrl_chk u_chk (.i_mclk(i_mclk), .i_rst(i_rst), .i_req_valid(i_req_valid),
  .i_req(i_req), .o_req_ready(o_req_ready), .o_req_reject(o_req_reject), .o_pins(o_pins),
  .o_self_refresh(o_self_refresh));
`default_nettype wire

// ===== dv/sdc_dram_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// device command decode
// ****************************************
module sdc_dram_model
  import sdc_pkg::*;
(
  input wire logic i_mclk,
  input wire sdc_pins_s i_pins,
  output logic [3:0] o_open,
  output logic o_pd,
  output logic o_sr,
  output logic o_apd,
  output logic [7:0] o_bad,
  output logic [7:0] o_refresh,
  output logic [BANK_W-1:0] o_mode_sel,
  output logic [MASK_W-1:0] o_stored
);
  logic prev_cke;
  logic nop;
  logic [3:0] cmd;
  logic [BANK_W-1:0] bk;
  assign cmd = {i_pins.cs_n, i_pins.ras_n, i_pins.cas_n, i_pins.we_n};
  assign nop = cmd[3] || (cmd == 4'h7);
  assign bk = i_pins.bank;
  initial begin
    {prev_cke, o_open, o_pd, o_sr, o_apd, o_bad, o_refresh, o_mode_sel, o_stored} = '0;
  end
  // exit is taken on the cke edge itself, not at the next clock
  always @(posedge i_pins.cke) begin
    o_sr <= 1'b0;
  end
  always @(posedge i_mclk) begin
    prev_cke <= i_pins.cke;
    if (o_sr) begin
      // exit needs no earlier cke sample
      if (i_pins.cke) o_sr <= 1'b0;
      else if (i_pins.on_die_termination) o_bad <= o_bad + 8'h01;
    end else if (o_pd) begin
      if (i_pins.cke) o_pd <= 1'b0;
      if (i_pins.cke && !nop) o_bad <= o_bad + 8'h01;
    end else if (prev_cke && !i_pins.cke) begin
      if (cmd == 4'h1 && o_open == 4'h0) o_sr <= 1'b1;
      else if (nop) {o_pd, o_apd} <= {1'b1, |o_open};
      else o_bad <= o_bad + 8'h01;
    end else if (prev_cke && !cmd[3]) begin
      case (cmd[2:0])
        3'h3: o_open[bk] <= 1'b1;
        3'h2: begin
          if (i_pins.addr[AUTO_PRECHARGE_BIT]) o_open <= 4'h0;
          else o_open[bk] <= 1'b0;
        end
        3'h1: begin
          if (o_open == 4'h0) o_refresh <= o_refresh + 8'h01;
          else o_bad <= o_bad + 8'h01;
        end
        3'h0: o_mode_sel <= bk;
        3'h5, 3'h4: begin
          if (!o_open[bk]) o_bad <= o_bad + 8'h01;
          if (!cmd[0]) o_stored <= ~i_pins.write_mask;
          if (i_pins.addr[AUTO_PRECHARGE_BIT]) o_open[bk] <= 1'b0;
        end
        default: ;
      endcase
    end
  end
endmodule : sdc_dram_model
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import sdc_pkg::*;
;
  logic i_mclk, i_rst, i_req_valid, i_termination_enabled, i_termination_level, i_burst_busy;
  sdc_req_s i_req;
  logic o_req_ready, o_req_reject, o_active_power_down, o_self_refresh, o_read_allowed;
  sdc_pins_s o_pins;
  logic [3:0] m_open;
  logic m_pd, m_sr, m_apd;
  logic [7:0] m_bad, m_refresh;
  logic [BANK_W-1:0] m_mode_sel;
  logic [MASK_W-1:0] m_mask;
  int error_cnt;
  int cmp_count;
  sdc_ctrl u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_req_valid(i_req_valid), .i_req(i_req),
    .i_termination_enabled(i_termination_enabled), .i_termination_level(i_termination_level),
    .i_burst_busy(i_burst_busy), .o_req_ready(o_req_ready), .o_req_reject(o_req_reject),
    .o_pins(o_pins), .o_active_power_down(o_active_power_down),
    .o_self_refresh(o_self_refresh), .o_read_allowed(o_read_allowed));
  sdc_dram_model u_mem (.i_mclk(i_mclk), .i_pins(o_pins), .o_open(m_open), .o_pd(m_pd),
    .o_sr(m_sr), .o_apd(m_apd), .o_bad(m_bad), .o_refresh(m_refresh),
    .o_mode_sel(m_mode_sel), .o_stored(m_mask));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [3:0] pcmd();
    return {o_pins.cs_n, o_pins.ras_n, o_pins.cas_n, o_pins.we_n};
  endfunction : pcmd
  task automatic check(input logic [19:0] got, input logic [19:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test
  // waits for ready, then holds valid for one clock edge; reject and pins looked at while they stand
  task automatic req(input sdc_op_e op, input logic ap, input logic [BANK_W-1:0] bk,
                     input logic [ADDR_W-1:0] ad, input logic [MASK_W-1:0] mk, input logic rej);
    int n;
    n = 0;
    while (o_req_ready !== 1'b1 && n < 400) begin
      @(negedge i_mclk);
      n++;
    end
    check(o_req_ready, 1'b1, "ready");
    i_req = '{op: op, auto_precharge: ap, bank: bk, addr: ad, write_mask: mk};
    i_req_valid = 1'b1;
    @(negedge i_mclk);
    i_req_valid = 1'b0;
    check(o_req_reject, rej, "reject");
  endtask : req
  // ****************************************
  // tests
  // ****************************************
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  initial begin
    #20000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    error_cnt = 0;
    cmp_count = 0;
    {i_rst, i_req_valid, i_req, i_burst_busy} = '0;
    i_rst = 1'b1;
    i_termination_enabled = 1'b1;
    i_termination_level = 1'b1;
    repeat (12) @(negedge i_mclk);
    check({o_pins.cke, pcmd(), o_pins.write_mask, o_pins.on_die_termination},
          {RST_CKE, 4'hF, 2'h3, RST_ODT}, "reset pins");
    i_rst = 1'b0;
    $display("test reset done");
    req(SDC_OP_CALIBRATE_ON, 1'b0, 2'h0, 13'h0000, 2'h3, 1'b0);
    check(o_pins.cke, 1'b1, "calibrate cke");
    req(SDC_OP_MODE_WRITE, 1'b0, 2'h1, 13'h0042, 2'h3, 1'b0);
    check({pcmd(), o_pins.bank, o_pins.addr}, {4'h0, 2'h1, 13'h0042}, "mode");
    req(SDC_OP_CALIBRATE_OFF, 1'b0, 2'h0, 13'h0000, 2'h3, 1'b0);
    $display("test calibrate done");
    req(SDC_OP_ACTIVATE, 1'b0, 2'h2, 13'h0ABC, 2'h3, 1'b0);
    check({pcmd(), o_pins.bank, o_pins.addr}, {4'h3, 2'h2, 13'h0ABC}, "act");
    req(SDC_OP_WRITE, 1'b0, 2'h2, 13'h0010, 2'h1, 1'b0);
    check({pcmd(), o_pins.bank, o_pins.write_mask}, {4'h4, 2'h2, 2'h1}, "write");
    req(SDC_OP_READ, 1'b0, 2'h2, 13'h0020, 2'h3, 1'b0);
    check({pcmd(), o_pins.addr}, {4'h5, 13'h0020}, "read");
    i_burst_busy = 1'b1;
    req(SDC_OP_WRITE, 1'b0, 2'h2, 13'h0030, 2'h0, 1'b1);
    req(SDC_OP_POWER_DOWN, 1'b0, 2'h0, 13'h0000, 2'h3, 1'b1);
    i_burst_busy = 1'b0;
    repeat (3) @(negedge i_mclk);
    req(SDC_OP_REFRESH, 1'b0, 2'h0, 13'h0000, 2'h3, 1'b1);
    req(SDC_OP_SELF_REFRESH, 1'b0, 2'h0, 13'h0000, 2'h3, 1'b1);
    $display("test bank commands done");
    req(SDC_OP_POWER_DOWN, 1'b0, 2'h0, 13'h0000, 2'h3, 1'b0);
    check({o_pins.cke, pcmd(), o_active_power_down}, {1'b0, 4'hF, 1'b1}, "apd");
    check(o_pins.on_die_termination, 1'b1, "odt firm");
    i_termination_level = 1'b0;
    @(negedge i_mclk);
    check(o_pins.on_die_termination, 1'b0, "odt low");
    i_termination_level = 1'b1;
    req(SDC_OP_WAKE, 1'b0, 2'h0, 13'h0000, 2'h3, 1'b1);
    req(SDC_OP_WAKE, 1'b0, 2'h0, 13'h0000, 2'h3, 1'b0);
    check({o_pins.cke, m_apd}, 2'h3, "wake");
    $display("test power down done");
    req(SDC_OP_PRECHARGE_ALL, 1'b0, 2'h0, 13'h0000, 2'h3, 1'b0);
    check({pcmd(), o_pins.addr[AUTO_PRECHARGE_BIT]}, {4'h2, 1'b1}, "pre all");
    req(SDC_OP_REFRESH, 1'b0, 2'h3, 13'h1FFF, 2'h3, 1'b0);
    check(pcmd(), 4'h1, "refresh");
    req(SDC_OP_SELF_REFRESH, 1'b0, 2'h0, 13'h0000, 2'h3, 1'b0);
    check({o_pins.cke, pcmd()}, {1'b0, 4'h1}, "sr entry");
    @(negedge i_mclk);
    check({o_self_refresh, m_sr, o_pins.on_die_termination}, 3'h6, "in sr");
    repeat (3) @(negedge i_mclk);
    req(SDC_OP_WAKE, 1'b0, 2'h0, 13'h0000, 2'h3, 1'b0);
    check({o_pins.cke, m_sr}, 2'h2, "sr exit");
    req(SDC_OP_READ, 1'b0, 2'h0, 13'h0000, 2'h3, 1'b1);
    repeat (25) @(negedge i_mclk);
    req(SDC_OP_ACTIVATE, 1'b0, 2'h0, 13'h0001, 2'h3, 1'b0);
    req(SDC_OP_READ, 1'b0, 2'h0, 13'h0008, 2'h3, 1'b1);
    check(o_read_allowed, 1'b0, "read blocked");
    repeat (200) @(negedge i_mclk);
    check(o_read_allowed, 1'b1, "read allowed");
    req(SDC_OP_READ, 1'b1, 2'h0, 13'h0008, 2'h3, 1'b0);
    check({pcmd(), o_pins.addr}, {4'h5, 13'h0408}, "read ap");
    req(SDC_OP_NOP, 1'b0, 2'h0, 13'h0000, 2'h3, 1'b0);
    check(pcmd(), 4'h7, "nop");
    req(SDC_OP_ACTIVATE, 1'b0, 2'h1, 13'h0005, 2'h3, 1'b0);
    req(SDC_OP_PRECHARGE, 1'b0, 2'h1, 13'h1FFF, 2'h3, 1'b0);
    check({pcmd(), o_pins.bank, o_pins.addr[AUTO_PRECHARGE_BIT]},
          {4'h2, 2'h1, 1'b0}, "pre one");
    req(SDC_OP_REFRESH, 1'b0, 2'h0, 13'h0000, 2'h3, 1'b0);
    @(negedge i_mclk);
    $display("test self refresh done");
    check({m_bad, m_refresh}, {8'h00, 8'h02}, "model counts");
    check({m_open, m_mode_sel, m_mask}, {4'h0, 2'h1, 2'h2}, "model state");
    end_of_test();
  end
endmodule : testbench
`default_nettype wire

// ===== src/sdc_bank_tracker.sv
`timescale 1ns/1ps
`default_nettype none
// remembers which banks hold an open row
module sdc_bank_tracker
  import sdc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_open,
  input wire logic i_close,
  input wire logic i_close_all,
  input wire logic [BANK_W-1:0] i_bank,
  output logic o_any_open
);
  typedef struct packed {
    logic [(1<<BANK_W)-1:0] open;
  } sdc_bank_s;

  sdc_bank_s st_reg;
  sdc_bank_s st_next;

  always_comb begin
    st_next = st_reg;
    if (i_close_all) begin
      st_next.open = '0;
    end else if (i_close) begin
      st_next.open[i_bank] = 1'b0;
    end else if (i_open) begin
      st_next.open[i_bank] = 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_any_open = |st_reg.open;
endmodule : sdc_bank_tracker
`default_nettype wire

// ===== src/sdc_ctrl.sv
// Behaviour
// - commands are cs, ras, cas, we and cke levels valid at rising edge
// - burst of four runs to end; no command cuts it
// - controller limits power-down time by refresh need; here power-down ends only on a user wake request
// - transition follows prior state, previous and current cke, current command
// - only defined state and sequence combinations are issued
// - after self refresh exit only nop until delays; no read before 200 clocks
// - self refresh entered only from all banks idle with refresh and cke falling
// - power-down entry and exit edges carry only nop or deselect
// - self refresh exit edge carries only nop or deselect
// - no power-down or self refresh while an operation runs
// - cke held three clocks after every change
// - cke stays high during driver impedance calibration
// - termination pin driven firm in power-down when enabled
// - write mask low stores the beat, high suppresses; driven with data
`timescale 1ns/1ps
`default_nettype none
module sdc_ctrl
  import sdc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_req_valid,
  input wire sdc_req_s i_req,
  input wire logic i_termination_enabled,
  input wire logic i_termination_level,
  input wire logic i_burst_busy,
  output logic o_req_ready,
  output logic o_req_reject,
  output sdc_pins_s o_pins,
  output logic o_active_power_down,
  output logic o_self_refresh,
  output logic o_read_allowed
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    sdc_state_e state;
    sdc_pins_s pins;
    logic ready;
    logic reject;
    logic active_pd;
    logic read_ok;
    logic burst_q1;
    logic burst_q2;
    logic in_sr;
  } sdc_ctrl_s;

  sdc_ctrl_s st_reg;
  sdc_ctrl_s st_next;

  logic any_open;
  logic hold_busy;
  logic exit_busy;
  logic read_busy;
  logic hold_load;
  logic exit_load;
  logic bank_open;
  logic bank_close;
  logic bank_close_all;

  // ****************************************
  // pin encoding
  // ****************************************
  function automatic sdc_pins_s drive_cmd(input sdc_pins_s base, input logic cs_n,
                                         input logic ras_n, input logic cas_n,
                                         input logic we_n);
    sdc_pins_s p;
    p = base;
    p.cs_n = cs_n;
    p.ras_n = ras_n;
    p.cas_n = cas_n;
    p.we_n = we_n;
    return p;
  endfunction : drive_cmd

  sdc_hold_timer u_cke_hold (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_load(hold_load),
    .i_value(CNT_W'(CLOCK_ENABLE_MIN_HOLD_CLKS - 1)),
    .o_busy(hold_busy)
  );

  sdc_hold_timer u_exit_nonread (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_load(exit_load),
    .i_value(CNT_W'(SELF_REFRESH_EXIT_NONREAD_DELAY_CLKS)),
    .o_busy(exit_busy)
  );

  sdc_hold_timer u_exit_read (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_load(exit_load),
    .i_value(CNT_W'(SELF_REFRESH_EXIT_READ_DELAY_CLKS)),
    .o_busy(read_busy)
  );

  sdc_bank_tracker u_banks (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_open(bank_open),
    .i_close(bank_close),
    .i_close_all(bank_close_all),
    .i_bank(i_req.bank),
    .o_any_open(any_open)
  );

  // ****************************************
  // command sequencing
  // ****************************************
  always_comb begin
    logic take;
    logic busy_op;
    take = 1'b0;
    busy_op = 1'b0;
    st_next = st_reg;
    hold_load = 1'b0;
    exit_load = 1'b0;
    bank_open = 1'b0;
    bank_close = 1'b0;
    bank_close_all = 1'b0;
    // a burst keeps the device busy two cycles past the flag
    st_next.burst_q1 = i_burst_busy;
    st_next.burst_q2 = st_reg.burst_q1;
    busy_op = i_burst_busy | st_reg.burst_q1 | st_reg.burst_q2;
    st_next.reject = 1'b0;
    // default edge: deselect, address and mask held quiet
    st_next.pins = drive_cmd(st_reg.pins, 1'b1, 1'b1, 1'b1, 1'b1);
    st_next.pins.write_mask = '1;
    // termination level firm whenever enabled, kept off in self refresh
    st_next.pins.on_die_termination = i_termination_enabled & i_termination_level
      & (st_reg.state != SDC_ST_SELF_REFRESH);
    st_next.read_ok = ~read_busy & (st_reg.state == SDC_ST_IDLE
      || st_reg.state == SDC_ST_ACTIVE);
    if (i_req_valid && st_reg.ready) begin
      take = 1'b1;
    end
    case (st_reg.state)
      SDC_ST_IDLE, SDC_ST_ACTIVE: begin
        if (take) begin
          case (i_req.op)
            SDC_OP_NOP: begin
              st_next.pins = drive_cmd(st_reg.pins, 1'b0, 1'b1, 1'b1, 1'b1);
            end
            SDC_OP_ACTIVATE: begin
              if (busy_op) begin
                st_next.reject = 1'b1;
              end else begin
                st_next.pins = drive_cmd(st_reg.pins, 1'b0, 1'b0, 1'b1, 1'b1);
                st_next.pins.bank = i_req.bank;
                st_next.pins.addr = i_req.addr;
                bank_open = 1'b1;
              end
            end
            SDC_OP_PRECHARGE, SDC_OP_PRECHARGE_ALL: begin
              if (busy_op) begin
                st_next.reject = 1'b1;
              end else begin
                st_next.pins = drive_cmd(st_reg.pins, 1'b0, 1'b0, 1'b1, 1'b0);
                st_next.pins.bank = i_req.bank;
                st_next.pins.addr = '0;
                st_next.pins.addr[AUTO_PRECHARGE_BIT] = (i_req.op == SDC_OP_PRECHARGE_ALL);
                bank_close = (i_req.op == SDC_OP_PRECHARGE);
                bank_close_all = (i_req.op == SDC_OP_PRECHARGE_ALL);
              end
            end
            SDC_OP_READ, SDC_OP_WRITE: begin
              if (busy_op || !any_open || (i_req.op == SDC_OP_READ && read_busy)) begin
                st_next.reject = 1'b1;
              end else begin
                st_next.pins = drive_cmd(st_reg.pins, 1'b0, 1'b1, 1'b0,
                  i_req.op == SDC_OP_READ);
                st_next.pins.bank = i_req.bank;
                st_next.pins.addr = i_req.addr;
                st_next.pins.addr[AUTO_PRECHARGE_BIT] = i_req.auto_precharge;
                st_next.pins.write_mask = i_req.write_mask;
                // auto precharge closes the row in the tracker on the edge that issues the command
                bank_close = i_req.auto_precharge;
              end
            end
            SDC_OP_MODE_WRITE: begin
              if (busy_op || any_open) begin
                st_next.reject = 1'b1;
              end else begin
                st_next.pins = drive_cmd(st_reg.pins, 1'b0, 1'b0, 1'b0, 1'b0);
                st_next.pins.bank = i_req.bank;
                st_next.pins.addr = i_req.addr;
              end
            end
            SDC_OP_REFRESH: begin
              if (busy_op || any_open) begin
                st_next.reject = 1'b1;
              end else begin
                st_next.pins = drive_cmd(st_reg.pins, 1'b0, 1'b0, 1'b0, 1'b1);
              end
            end
            SDC_OP_SELF_REFRESH: begin
              if (busy_op || any_open || hold_busy) begin
                st_next.reject = 1'b1;
              end else begin
                st_next.pins = drive_cmd(st_reg.pins, 1'b0, 1'b0, 1'b0, 1'b1);
                st_next.pins.cke = 1'b0;
                hold_load = 1'b1;
                st_next.state = SDC_ST_SELF_REFRESH;
              end
            end
            SDC_OP_POWER_DOWN: begin
              if (busy_op || hold_busy) begin
                st_next.reject = 1'b1;
              end else begin
                st_next.pins.cke = 1'b0;
                hold_load = 1'b1;
                st_next.active_pd = any_open;
                st_next.state = SDC_ST_POWER_DOWN;
              end
            end
            SDC_OP_CALIBRATE_ON: begin
              if (busy_op) begin
                st_next.reject = 1'b1;
              end else begin
                st_next.state = SDC_ST_CALIBRATE;
                st_next.pins.cke = 1'b1;
                hold_load = 1'b1;
              end
            end
            default: begin
              st_next.reject = 1'b1;
            end
          endcase
        end
      end
      SDC_ST_POWER_DOWN: begin
        // refresh budget is the user's: wake is issued by request only
        if (take) begin
          if (i_req.op == SDC_OP_WAKE && !hold_busy) begin
            st_next.pins.cke = 1'b1;
            hold_load = 1'b1;
            st_next.active_pd = 1'b0;
            st_next.state = any_open ? SDC_ST_ACTIVE : SDC_ST_IDLE;
          end else begin
            st_next.reject = 1'b1;
          end
        end
      end
      SDC_ST_SELF_REFRESH: begin
        if (take) begin
          if (i_req.op == SDC_OP_WAKE && !hold_busy) begin
            st_next.pins.cke = 1'b1;
            hold_load = 1'b1;
            exit_load = 1'b1;
            st_next.state = SDC_ST_SR_EXIT;
          end else begin
            st_next.reject = 1'b1;
          end
        end
      end
      SDC_ST_SR_EXIT: begin
        // only deselect on the pins until the non-read delay ends
        if (take) begin
          st_next.reject = 1'b1;
        end
        if (!exit_busy && !hold_busy) begin
          st_next.state = SDC_ST_IDLE;
        end
      end
      SDC_ST_CALIBRATE: begin
        st_next.pins.cke = 1'b1;
        if (take) begin
          if (i_req.op == SDC_OP_CALIBRATE_OFF) begin
            st_next.state = any_open ? SDC_ST_ACTIVE : SDC_ST_IDLE;
          end else if (i_req.op == SDC_OP_MODE_WRITE) begin
            st_next.pins = drive_cmd(st_reg.pins, 1'b0, 1'b0, 1'b0, 1'b0);
            st_next.pins.bank = i_req.bank;
            st_next.pins.addr = i_req.addr;
          end else begin
            st_next.reject = 1'b1;
          end
        end
      end
      default: begin
        st_next.state = SDC_ST_IDLE;
      end
    endcase
    if (st_next.state == SDC_ST_IDLE && any_open && !bank_close && !bank_close_all) begin
      st_next.state = SDC_ST_ACTIVE;
    end else if (st_next.state == SDC_ST_ACTIVE && (bank_close_all || !any_open)
                 && !bank_open) begin
      st_next.state = SDC_ST_IDLE;
    end
    st_next.in_sr = (st_next.state == SDC_ST_SELF_REFRESH);
    // one request per two cycles keeps pin and tracker views aligned
    st_next.ready = ~take;
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_reg <= '0;
      st_reg.state <= SDC_ST_IDLE;
      st_reg.pins <= '0;
      st_reg.pins.cke <= RST_CKE;
      st_reg.pins.cs_n <= 1'b1;
      st_reg.pins.ras_n <= 1'b1;
      st_reg.pins.cas_n <= 1'b1;
      st_reg.pins.we_n <= 1'b1;
      st_reg.pins.write_mask <= '1;
      st_reg.pins.on_die_termination <= RST_ODT;
    end else begin
      st_reg <= st_next;
    end
  end

  always_comb begin
    o_pins = st_reg.pins;
    o_req_ready = st_reg.ready;
    o_req_reject = st_reg.reject;
    o_active_power_down = st_reg.active_pd;
    o_self_refresh = st_reg.in_sr;
    o_read_allowed = st_reg.read_ok;
  end

endmodule : sdc_ctrl
`default_nettype wire

// ===== src/sdc_hold_timer.sv
`timescale 1ns/1ps
`default_nettype none
// counts down from a load value; busy while nonzero
module sdc_hold_timer
  import sdc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_load,
  input wire logic [CNT_W-1:0] i_value,
  output logic o_busy
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } sdc_tmr_s;

  sdc_tmr_s st_reg;
  sdc_tmr_s st_next;

  always_comb begin
    st_next = st_reg;
    if (i_load) begin
      st_next.cnt = i_value;
    end else if (st_reg.cnt != CNT_ZERO) begin
      st_next.cnt = st_reg.cnt - 8'h01;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_busy = (st_reg.cnt != CNT_ZERO);
endmodule : sdc_hold_timer
`default_nettype wire

// ===== src/sdc_pkg.sv
package sdc_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int BANK_W = 2;
  localparam int ADDR_W = 13;
  localparam int MASK_W = 2;
  localparam int AUTO_PRECHARGE_BIT = 10;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLOCK_ENABLE_MIN_HOLD_CLKS = 3;
  localparam int SELF_REFRESH_EXIT_READ_DELAY_CLKS = 200;
  localparam int SELF_REFRESH_EXIT_NONREAD_DELAY_NS = 200;
  localparam int SELF_REFRESH_EXIT_NONREAD_DELAY_CLKS =
    (SELF_REFRESH_EXIT_NONREAD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic RST_CKE = 1'b0;
  localparam logic RST_ODT = 1'b0;

  // ****************************************
  // user commands
  // ****************************************
  typedef enum logic [3:0] {
    SDC_OP_NOP,
    SDC_OP_ACTIVATE,
    SDC_OP_PRECHARGE,
    SDC_OP_PRECHARGE_ALL,
    SDC_OP_READ,
    SDC_OP_WRITE,
    SDC_OP_MODE_WRITE,
    SDC_OP_REFRESH,
    SDC_OP_SELF_REFRESH,
    SDC_OP_POWER_DOWN,
    SDC_OP_WAKE,
    SDC_OP_CALIBRATE_ON,
    SDC_OP_CALIBRATE_OFF
  } sdc_op_e;

  typedef struct packed {
    sdc_op_e op;
    logic auto_precharge;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic [MASK_W-1:0] write_mask;
  } sdc_req_s;

  // pin bundle; strobes are active low
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic [MASK_W-1:0] write_mask;
    logic on_die_termination;
  } sdc_pins_s;

  typedef enum logic [2:0] {
    SDC_ST_IDLE,
    SDC_ST_ACTIVE,
    SDC_ST_POWER_DOWN,
    SDC_ST_SELF_REFRESH,
    SDC_ST_SR_EXIT,
    SDC_ST_CALIBRATE
  } sdc_state_e;

endpackage : sdc_pkg
